/* File: scp_pkg.sv */
// Constants shared by the system control coprocessor files.
// Assumes a 32-bit core that presents one coprocessor instruction per pulse.
// How it works
// - Registers reached only by privileged transfer instructions
// - Other coprocessor forms or unprivileged transfers are rejected
// - Accept only coprocessor number fifteen in bits 11:8
// - Direction bit zero writes, one reads
// - Register 0 returns fixed identification with revision nibble
// - Translation, alignment, cache, write buffer enable bits
// - Three fixed configuration bits read one, ignore writes
// - Endianness bit: zero little, one big
// - Stores system, ROM protection and vector location
// - Unused control bits read undefined; software writes zero
// - Register 2 keeps translation base bits 31:14 only
// - Register 3 holds sixteen 2-bit domain fields
// - Register 7 write with aux 0111 and opcode 0 invalidates cache
// - Register 8 aux 0111: opcode 0 all, 1 entry
// - Whole invalidate removes every unlocked TLB entry
// - Entry invalidate uses virtual address from core register
// - Registers 4, 9-12, 14-15 reserved; 13 unused
// - Write buffer enable sits at control bit 3
// - Cache starts disabled after reset
// - Address translation starts disabled after reset
package scp_pkg;
    // Instruction field positions
    localparam int          INS_CLASS_LSB  = 24;
    localparam int          INS_LDST_LSB   = 25;
    localparam int          INS_DIR_BIT    = 20;
    localparam int          INS_CRN_LSB    = 16;
    localparam int          INS_CPNUM_LSB  = 8;
    localparam int          INS_OP2_LSB    = 5;
    localparam int          INS_XFER_BIT   = 4;
    localparam int          INS_CRM_LSB    = 0;
    // Instruction encodings
    localparam logic [3:0]  CLASS_COPROC   = 4'he;
    localparam logic [2:0]  CLASS_LDST     = 3'h6;
    localparam logic [3:0]  CP_NUMBER      = 4'hf;
    // Register numbers
    localparam logic [3:0]  REG_ID         = 4'h0;
    localparam logic [3:0]  REG_CTRL       = 4'h1;
    localparam logic [3:0]  REG_TTB        = 4'h2;
    localparam logic [3:0]  REG_DOMAIN     = 4'h3;
    localparam logic [3:0]  REG_CACHE_OP   = 4'h7;
    localparam logic [3:0]  REG_TLB_OP     = 4'h8;
    // Maintenance sub-codes
    localparam logic [3:0]  AUX_MAINT      = 4'h7;
    localparam logic [2:0]  OP2_ALL        = 3'h0;
    localparam logic [2:0]  OP2_ENTRY      = 3'h1;
    // Control register bit positions
    localparam int          CTRL_MMU       = 0;
    localparam int          CTRL_ALIGN     = 1;
    localparam int          CTRL_CACHE     = 2;
    localparam int          CTRL_WBUF      = 3;
    localparam int          CTRL_ENDIAN    = 7;
    localparam int          CTRL_SYS_PROT  = 8;
    localparam int          CTRL_ROM_PROT  = 9;
    localparam int          CTRL_VECTORS   = 13;
    // Register masks, reset values and the value unused numbers read
    localparam logic [31:0] CTRL_FIXED_ONE = 32'h0000_0070;
    localparam logic [31:0] CTRL_STORED    = 32'h0000_238f;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] TTB_MASK       = 32'hffff_c000;
    localparam logic [31:0] TTB_RESET      = 32'h0000_0000;
    localparam logic [31:0] DOMAIN_RESET   = 32'h0000_0000;
    localparam logic [31:0] READ_UNDEF     = 32'h0000_0000;
endpackage

/* File: decode_if.sv */
// Decoded instruction fields passed from the decoder to the register file.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface decode_if;
    logic       xfer_ok;
    logic       reject;
    logic       read_dir;
    logic [3:0] target_register_select;
    logic [3:0] auxiliary_register_field;
    logic [2:0] op2;

    modport producer (output xfer_ok, output reject, output read_dir,
                      output target_register_select, output auxiliary_register_field, output op2);
    modport consumer (input xfer_ok, input reject, input read_dir,
                      input target_register_select, input auxiliary_register_field, input op2);
endinterface

/* File: coproc_decoder.sv */
// Combinational decoder of coprocessor instructions aimed at this unit.
// Assumes the instruction and privilege level are stable while valid is high.
`timescale 1ns/1ps
module coproc_decoder
    import scp_pkg::*;
(
    input  wire logic [31:0] i_instr,
    input  wire logic        i_valid,
    input  wire logic        i_privileged,
    decode_if.producer       dec
);
    logic is_ours;
    logic is_xfer;
    logic is_data_op;
    logic is_ldst;

    // Instruction class detection
    always_comb begin
        is_ours    = i_instr[INS_CPNUM_LSB +: 4] == CP_NUMBER;
        is_xfer    = (i_instr[INS_CLASS_LSB +: 4] == CLASS_COPROC) & i_instr[INS_XFER_BIT];
        is_data_op = (i_instr[INS_CLASS_LSB +: 4] == CLASS_COPROC) & ~i_instr[INS_XFER_BIT];
        is_ldst    = i_instr[INS_LDST_LSB +: 3] == CLASS_LDST;
    end

    // Other coprocessors' instructions are left alone, neither taken nor trapped
    always_comb begin
        dec.xfer_ok  = i_valid & is_ours & is_xfer & i_privileged;
        dec.reject   = i_valid & is_ours
                     & ((is_xfer & ~i_privileged) | is_data_op | is_ldst);
        dec.read_dir = i_instr[INS_DIR_BIT];
        dec.target_register_select      = i_instr[INS_CRN_LSB +: 4];
        dec.auxiliary_register_field      = i_instr[INS_CRM_LSB +: 4];
        dec.op2      = i_instr[INS_OP2_LSB +: 3];
    end
endmodule // coproc_decoder

/* File: system_control_coprocessor.sv */
// System control coprocessor: configuration registers and maintenance strobes.
// Assumes i_instr_valid and i_core_data come from logic on i_ref_clk.
`timescale 1ns/1ps
module system_control_coprocessor
    import scp_pkg::*;
#(
    parameter logic [31:0] CHIP_ID = 32'h5a5a_0001 // Arbitrary value; low nibble is revision
)
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_instr_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_privileged,
    input  wire logic [31:0] i_core_data,
    output logic             o_accept,
    output logic             o_undefined,
    output logic             o_read_valid,
    output logic [31:0]      o_read_data,
    output logic             o_mmu_enable,
    output logic             o_align_enable,
    output logic             o_cache_enable,
    output logic             o_wbuf_enable,
    output logic             o_big_endian,
    output logic             o_sys_protect,
    output logic             o_rom_protect,
    output logic             o_high_vectors,
    output logic [31:0]      o_table_base,
    output logic [31:0]      o_domain_perm,
    output logic             o_cache_invalidate,
    output logic             o_tlb_invalidate_all,
    output logic             o_tlb_invalidate_entry,
    output logic [31:0]      o_tlb_invalidate_addr
);
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [31:0] ctrl_q;
    logic [31:0] ttb_q;
    logic [31:0] domain_q;
    logic        wr_en;
    logic        rd_en;
    logic        maint_aux;
    logic [31:0] read_d;
    logic        accept_q;
    logic        undef_q;
    logic        read_valid_q;
    logic [31:0] read_data_q;
    logic        cache_inv_q;
    logic        tlb_all_q;
    logic        tlb_entry_q;
    logic [31:0] tlb_addr_q;

    decode_if dec ();

    coproc_decoder u_decoder (
        .i_instr      (i_instr),
        .i_valid      (i_instr_valid),
        .i_privileged (i_privileged),
        .dec          (dec.producer)
    );

    // Reset release through two flops so release never lands near a clock edge
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Taken transfer split by direction
    assign wr_en     = dec.xfer_ok & ~dec.read_dir;
    assign rd_en     = dec.xfer_ok & dec.read_dir;
    assign maint_aux = dec.auxiliary_register_field == AUX_MAINT;

    // Control register; every stored bit updates in the same edge
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && dec.target_register_select == REG_CTRL) begin
            ctrl_q <= i_core_data & CTRL_STORED;
        end
    end

    // Translation table base keeps only its valid upper bits
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ttb_q <= TTB_RESET;
        end else if (wr_en && dec.target_register_select == REG_TTB) begin
            ttb_q <= i_core_data & TTB_MASK;
        end
    end

    // Domain access fields, two bits per domain, stored as one word
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            domain_q <= DOMAIN_RESET;
        end else if (wr_en && dec.target_register_select == REG_DOMAIN) begin
            domain_q <= i_core_data;
        end
    end

    // Read multiplexer; write-only and reserved numbers read as zero
    always_comb begin
        case (dec.target_register_select)
            REG_ID:     read_d = CHIP_ID;
            REG_CTRL:   read_d = ctrl_q | CTRL_FIXED_ONE;
            REG_TTB:    read_d = ttb_q;
            REG_DOMAIN: read_d = domain_q;
            default:    read_d = READ_UNDEF;
        endcase
    end

    // Handshake answers, one cycle after the instruction is presented
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accept_q     <= 1'b0;
            undef_q      <= 1'b0;
            read_valid_q <= 1'b0;
        end else begin
            accept_q     <= dec.xfer_ok;
            undef_q      <= dec.reject;
            read_valid_q <= rd_en;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data_q <= 32'h0000_0000;
        end else if (rd_en) begin
            read_data_q <= read_d;
        end
    end

    // Maintenance strobes; writes to ID or reserved numbers fall through here
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_inv_q <= 1'b0;
            tlb_all_q   <= 1'b0;
            tlb_entry_q <= 1'b0;
        end else begin
            cache_inv_q <= wr_en & maint_aux & (dec.target_register_select == REG_CACHE_OP)
                         & (dec.op2 == OP2_ALL);
            tlb_all_q   <= wr_en & maint_aux & (dec.target_register_select == REG_TLB_OP)
                         & (dec.op2 == OP2_ALL);
            tlb_entry_q <= wr_en & maint_aux & (dec.target_register_select == REG_TLB_OP)
                         & (dec.op2 == OP2_ENTRY);
        end
    end

    // Virtual address for single-entry invalidate, held until the next one
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tlb_addr_q <= 32'h0000_0000;
        end else if (wr_en && maint_aux && dec.target_register_select == REG_TLB_OP && dec.op2 == OP2_ENTRY) begin
            tlb_addr_q <= i_core_data;
        end
    end

    // Outputs taken straight from the flops above
    assign o_accept               = accept_q;
    assign o_undefined            = undef_q;
    assign o_read_valid           = read_valid_q;
    assign o_read_data            = read_data_q;
    assign o_mmu_enable           = ctrl_q[CTRL_MMU];
    assign o_align_enable         = ctrl_q[CTRL_ALIGN];
    assign o_cache_enable         = ctrl_q[CTRL_CACHE];
    assign o_wbuf_enable          = ctrl_q[CTRL_WBUF];
    assign o_big_endian           = ctrl_q[CTRL_ENDIAN];
    assign o_sys_protect          = ctrl_q[CTRL_SYS_PROT];
    assign o_rom_protect          = ctrl_q[CTRL_ROM_PROT];
    assign o_high_vectors         = ctrl_q[CTRL_VECTORS];
    assign o_table_base           = ttb_q;
    assign o_domain_perm          = domain_q;
    assign o_cache_invalidate     = cache_inv_q;
    assign o_tlb_invalidate_all   = tlb_all_q;
    assign o_tlb_invalidate_entry = tlb_entry_q;
    assign o_tlb_invalidate_addr  = tlb_addr_q;
endmodule // system_control_coprocessor

/* File: scp_sva.sv */
// Port checker for the system control coprocessor.
// Assumes it is bound to the top module and is handed its CHIP_ID.
`timescale 1ns/1ps
module scp_sva #(
    parameter logic [31:0] CHIP_ID = 32'h0
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_instr_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_privileged,
    input  wire logic [31:0] i_core_data,
    input  wire logic        o_accept,
    input  wire logic        o_undefined,
    input  wire logic        o_read_valid,
    input  wire logic [31:0] o_read_data,
    input  wire logic        o_mmu_enable,
    input  wire logic        o_wbuf_enable,
    input  wire logic [31:0] o_table_base,
    input  wire logic        o_cache_invalidate,
    input  wire logic        o_tlb_invalidate_entry,
    input  wire logic [31:0] o_tlb_invalidate_addr
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // Decoded views; privilege kept apart so traps can be checked too
    logic       xf;
    logic       wr;
    logic       mnt;
    logic [3:0] rn;
    assign rn  = i_instr[19:16];
    assign xf  = i_instr_valid && i_instr[27:24] == 4'he && i_instr[4] && i_instr[11:8] == 4'hf;
    assign wr  = xf && i_privileged && !i_instr[20];
    assign mnt = wr && i_instr[3:0] == 4'h7;
    a_accept_cause: assert property (o_accept |-> $past(xf && i_privileged))
        else $error("accept without a privileged transfer");
    a_unpriv_trap: assert property (xf && !i_privileged |=> o_undefined && !o_accept)
        else $error("unprivileged transfer not trapped");
    a_dataop_trap: assert property (
        i_instr_valid && i_instr[27:24] == 4'he && !i_instr[4]
        && i_instr[11:8] == 4'hf |=> o_undefined)
        else $error("data operation not trapped");
    a_id_read: assert property (
        xf && i_privileged && i_instr[20] && rn == 4'h0
        |=> o_read_valid && o_read_data == CHIP_ID)
        else $error("identification read wrong");
    a_fixed_ones: assert property (o_read_valid && $past(rn) == 4'h1 |-> o_read_data[6:4] == 3'h7)
        else $error("fixed control bits not one");
    a_base_low: assert property (o_table_base[13:0] == 14'h0)
        else $error("table base low bits set");
    a_ctrl_write: assert property (
        wr && rn == 4'h1 |=> o_mmu_enable == $past(i_core_data[0])
        && o_wbuf_enable == $past(i_core_data[3]))
        else $error("control write not applied");
    a_cache_inv: assert property (o_cache_invalidate |-> $past(mnt && rn == 4'h7 && i_instr[7:5] == 3'h0))
        else $error("cache invalidate without its write");
    // Strobe may stay up only when a second entry invalidate follows back to back
    a_tlb_entry: assert property (
        mnt && rn == 4'h8 && i_instr[7:5] == 3'h1
        |=> (o_tlb_invalidate_entry && o_tlb_invalidate_addr == $past(i_core_data))
        ##1 (!o_tlb_invalidate_entry || $past(mnt && rn == 4'h8 && i_instr[7:5] == 3'h1)))
        else $error("entry invalidate wrong");
    c_read: cover property (o_read_valid);
    c_trap: cover property (o_undefined);
    c_tlb:  cover property (o_tlb_invalidate_entry);
endmodule // scp_sva
bind system_control_coprocessor scp_sva #(.CHIP_ID(CHIP_ID)) sva_u (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_privileged(i_privileged), .i_core_data(i_core_data),
    .o_accept(o_accept), .o_undefined(o_undefined), .o_read_valid(o_read_valid),
    .o_read_data(o_read_data), .o_mmu_enable(o_mmu_enable), .o_wbuf_enable(o_wbuf_enable),
    .o_table_base(o_table_base), .o_cache_invalidate(o_cache_invalidate),
    .o_tlb_invalidate_entry(o_tlb_invalidate_entry),
    .o_tlb_invalidate_addr(o_tlb_invalidate_addr));

/* File: core_model.sv */
// Core-side model that issues coprocessor instructions.
// Assumes the bench calls its tasks; lines move on the falling edge.
`timescale 1ns/1ps
module core_model (
    input  wire logic        i_ref_clk,
    output logic             o_valid,
    output logic [31:0]      o_instr,
    output logic             o_priv,
    output logic [31:0]      o_data
);
    // Quiet start so the block sees no instruction in reset
    initial begin
        o_valid = 1'b0;
        o_instr = 32'h0;
        o_priv  = 1'b0;
        o_data  = 32'h0;
    end
    // Build a transfer word; first opcode always zero
    function automatic logic [31:0] mk(input logic d, input logic [3:0] rn, input logic [3:0] rm,
                                       input logic [2:0] o2, input logic x);
        return {4'he, 4'he, 3'h0, d, rn, 4'h0, 4'hf, o2, x, rm};
    endfunction
    // One instruction per call; calls in a row give back-to-back traffic
    task automatic issue(input logic [31:0] ins, input logic pv, input logic [31:0] d);
        @(negedge i_ref_clk);
        o_valid <= 1'b1;
        o_instr <= ins;
        o_priv  <= pv;
        o_data  <= d;
    endtask
    // Released lines flip so stale values cannot pass
    task automatic idle();
        @(negedge i_ref_clk);
        o_valid <= 1'b0;
        o_instr <= ~o_instr;
        o_data  <= ~o_data;
    endtask
endmodule // core_model

/* File: system_control_coprocessor_tb.sv */
// Self-checking bench for the system control coprocessor.
// Assumes core_model drives the instruction side; notes are checked in order.
`timescale 1ns/1ps
module system_control_coprocessor_tb;
    import scp_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h6b6b_0002; // Arbitrary value
    typedef struct packed {logic acc; logic und; logic rv; logic [31:0] rd;
                           logic [2:0] stb; logic [31:0] va;} note_s;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        valid, priv, acc, und, rv, mmu, aln, cen, wb, be, sp, rp, hv, ci, ta, te;
    logic [31:0] instr, data, rd, tbase, dp, va, r;
    logic [31:0] ce; // Control readback expected after the random write
    note_s       q[$];
    note_s       n;
    int          mismatches = 0;
    int          checks = 0;
    int          cycles = 0;
    core_model core_u (.i_ref_clk(clk), .o_valid(valid), .o_instr(instr), .o_priv(priv), .o_data(data));
    system_control_coprocessor #(.CHIP_ID(ID_VAL)) dut_u (
        .i_ref_clk(clk), .i_resetn(resetn), .i_instr_valid(valid), .i_instr(instr),
        .i_privileged(priv), .i_core_data(data), .o_accept(acc), .o_undefined(und),
        .o_read_valid(rv), .o_read_data(rd), .o_mmu_enable(mmu), .o_align_enable(aln),
        .o_cache_enable(cen), .o_wbuf_enable(wb), .o_big_endian(be), .o_sys_protect(sp),
        .o_rom_protect(rp), .o_high_vectors(hv), .o_table_base(tbase), .o_domain_perm(dp),
        .o_cache_invalidate(ci), .o_tlb_invalidate_all(ta), .o_tlb_invalidate_entry(te),
        .o_tlb_invalidate_addr(va));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Note the expected answer, then issue the transfer
    task automatic op(input logic d, input logic [3:0] rn, input logic [3:0] rm, input logic [2:0] o2,
                      input logic pv, input logic [31:0] v, input logic [31:0] e);
        logic w;
        w = pv && !d && rm == 4'h7;
        q.push_back('{pv, !pv, d && pv, e, {w && rn == 4'h7 && o2 == 3'h0,
                     w && rn == 4'h8 && o2 == 3'h0, w && rn == 4'h8 && o2 == 3'h1}, v});
        core_u.issue(core_u.mk(d, rn, rm, o2, 1'b1), pv, v);
    endtask
    // Every answer pulse takes the oldest note; stray answers count as errors
    always @(negedge clk) begin
        if (acc === 1'b1 || und === 1'b1) begin
            if (q.size() == 0) cmp("unexpected answer", 32'h0, 32'h1);
            else begin
                n = q.pop_front();
                cmp("accept", n.acc, acc);
                cmp("undefined", n.und, und);
                cmp("read_valid", n.rv, rv);
                if (n.rv) cmp("read_data", n.rd, rd);
                cmp("strobes", n.stb, {ci, ta, te});
                if (n.stb[0]) cmp("tlb_addr", n.va, va);
            end
        end
    end
    // Hang guard well above the planned run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(81966));
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        cmp("reset enables", 32'h0, {mmu, cen, wb});
        op(1'b1, REG_CTRL, 4'h0, 3'h0, 1'b1, 32'h0, CTRL_FIXED_ONE);
        op(1'b1, REG_ID, 4'h0, 3'h0, 1'b1, 32'h0, ID_VAL);
        op(1'b0, REG_CTRL, 4'h0, 3'h0, 1'b1, 32'h0000_000f, 32'h0);
        op(1'b1, REG_CTRL, 4'h0, 3'h0, 1'b1, 32'h0, 32'h0000_007f);
        cmp("enables", 32'hf, {wb, cen, aln, mmu});
        $display("test reset and enables done");
        r = $urandom() & CTRL_STORED;
        op(1'b0, REG_CTRL, 4'h0, 3'h0, 1'b1, r, 32'h0);
        op(1'b1, REG_CTRL, 4'h0, 3'h0, 1'b1, 32'h0, r | CTRL_FIXED_ONE);
        cmp("ctrl bits", {r[13], r[9:7]}, {hv, rp, sp, be});
        ce = r | CTRL_FIXED_ONE;
        // Unmasked write so the dropped low bits are really exercised
        r = $urandom();
        op(1'b0, REG_TTB, 4'h0, 3'h0, 1'b1, r, 32'h0);
        op(1'b1, REG_TTB, 4'h0, 3'h0, 1'b1, 32'h0, r & TTB_MASK);
        cmp("table base", r & TTB_MASK, tbase);
        r = $urandom();
        op(1'b0, REG_DOMAIN, 4'h0, 3'h0, 1'b1, r, 32'h0);
        op(1'b1, REG_DOMAIN, 4'h0, 3'h0, 1'b1, 32'h0, r);
        cmp("domains", r, dp);
        $display("test registers done");
        // Identification and reserved places absorb writes, read fixed
        for (int i = 0; i < 16; i++) begin
            if (i inside {[1:3], 7, 8}) continue;
            op(1'b0, 4'(i), 4'h0, 3'h0, 1'b1, $urandom(), 32'h0);
            op(1'b1, 4'(i), 4'h0, 3'h0, 1'b1, 32'h0, i == 0 ? ID_VAL : READ_UNDEF);
        end
        op(1'b0, REG_CTRL, 4'h0, 3'h0, 1'b0, 32'h0, 32'h0);
        op(1'b1, REG_DOMAIN, 4'h0, 3'h0, 1'b1, 32'h0, r);
        op(1'b1, REG_CTRL, 4'h0, 3'h0, 1'b1, 32'h0, ce);
        q.push_back('{1'b0, 1'b1, 1'b0, 32'h0, 3'h0, 32'h0});
        core_u.issue(core_u.mk(1'b0, REG_CTRL, 4'h0, 3'h0, 1'b0), 1'b1, 32'h0);
        q.push_back('{1'b0, 1'b1, 1'b0, 32'h0, 3'h0, 32'h0});
        core_u.issue({4'he, 3'h6, 13'h0, 4'hf, 8'h0}, 1'b1, 32'h0);
        core_u.issue(core_u.mk(1'b0, REG_CTRL, 4'h0, 3'h0, 1'b1) ^ 32'h100, 1'b1, 32'h0);
        $display("test refusals done");
        op(1'b0, REG_CACHE_OP, AUX_MAINT, OP2_ALL, 1'b1, 32'h0, 32'h0);
        op(1'b0, REG_TLB_OP, AUX_MAINT, OP2_ALL, 1'b1, 32'h0, 32'h0);
        op(1'b0, REG_TLB_OP, AUX_MAINT, OP2_ENTRY, 1'b1, $urandom(), 32'h0);
        op(1'b0, REG_TLB_OP, AUX_MAINT, 3'h2, 1'b1, 32'h0, 32'h0);
        op(1'b0, REG_CACHE_OP, 4'h6, OP2_ALL, 1'b1, 32'h0, 32'h0);
        core_u.idle();
        repeat (4) @(negedge clk);
        cmp("pending notes", 32'h0, 32'(q.size()));
        $display("test maintenance done");
        stop_test();
    end
endmodule // system_control_coprocessor_tb
